// [hw/tmr_core.sv]
/*
 16-bit timer with normal, clear-on-match and fast pwm modes behind a wishbone slave.
 assumes a classic wishbone master on the same 20 MHz clock; pin direction comes from a register.
*/
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
// What this block does
// RL1: mode 0 always counts up, never clears, wraps from maximum to zero.
// RL2: normal mode sets overflow when counter becomes zero; counting never clears it.
// RL3: software may write the counter at any time in normal mode.
// RL4: clear-on-match clears at compare A (mode 4) or capture (mode 12).
// RL5: clear-on-match compare A is unbuffered; top below count wraps through maximum.
// RL6: clear-on-match sets compare A or capture flag when count reaches top.
// RL7: output action 1 toggles output A on every match in clear-on-match.
// RL8: waveform reaches the pin only when its direction bit selects output.
// RL9: clear-on-match sets overflow only on maximum to zero roll.
// RL10: fast pwm top is 0xff, 0x1ff, 0x3ff, capture or compare A by mode.
// RL11: fast pwm counts up to top then clears on the following tick.
// RL12: non-inverting clears on match, sets at zero; inverting does the opposite.
// RL13: fast pwm action 2 and 3 select the two opposite polarities.
// RL14: fast pwm sets overflow at top, plus compare A or capture flag if top source.
// RL15: fixed top modes mask compare writes above the selected resolution.
// RL16: capture as top acts immediately; lower value wraps through zero first.
// RL17: fast pwm buffers compare A writes, loading them when the counter hits top.
// RL18: software keeps top at or above every compare value.
// RL19: software keeps a variable top at 0x0003 or more.
// RL20: fast pwm period is top plus one prescaled ticks.
// RL21: flags clear when software writes a one to them.
// RL22: output action 0 leaves the output state alone on matches.
// RL23: a counter write blocks compare matches on the next tick.
// RL24: counting, flag setting and output changes happen only on prescaled ticks.
module tmr_core
   import tmr_pkg::*;
(
   input wire logic clock, // 20 MHz clock
   input wire logic rstn, // synchronous reset, active low
   input wire tmr_pkg::tmr_wb_req_s wb_req, // wishbone request
   output logic [31:0] wb_dat_o, // wishbone read data
   output logic wb_ack_o, // wishbone acknowledge
   output logic wave_out_a, // pin level for channel a
   output logic wave_out_a_oe, // channel a pin driven
   output logic wave_out_b, // pin level for channel b
   output logic wave_out_b_oe // channel b pin driven
);
   tmr_ctrl_s ctrl_r;
   logic [3:0] flags_r;
   logic [15:0] counter_value_r;
   logic [15:0] compare_a_value_r;
   logic [15:0] compare_a_buf_r;
   logic [15:0] compare_b_value_r;
   logic [15:0] compare_b_buf_r;
   logic [15:0] capture_value_r;
   logic [1:0] pin_dir_r;
   logic [1:0] wave_r;
   logic [10:0] pre_r;
   logic block_r;
   logic tick;
   logic acc;
   logic wr;
   logic cnt_wr;
   logic [15:0] top;
   logic [15:0] mask;
   logic at_top;
   logic at_max;
   logic fast;
   logic clear_on_match_mode;
   logic match_a;
   logic match_b;
   logic [15:0] wdat;

   function automatic logic is_fast(input logic [3:0] m);
      is_fast = (m == TMR_M_FP8) || (m == TMR_M_FP9) || (m == TMR_M_FP10) ||
         (m == TMR_M_FP_CAP) || (m == TMR_M_FP_A);
   endfunction

   function automatic logic [15:0] fixed_mask(input logic [3:0] m);
      case (m)
         TMR_M_FP8: fixed_mask = TMR_TOP8;
         TMR_M_FP9: fixed_mask = TMR_TOP9;
         TMR_M_FP10: fixed_mask = TMR_TOP10;
         default: fixed_mask = TMR_MAX;
      endcase
   endfunction

   assign acc = wb_req.cyc && wb_req.stb;
   assign wr = acc && wb_req.we && !wb_ack_o;
   assign wdat = wb_req.dat[15:0];
   assign cnt_wr = wr && (wb_req.adr == TMR_CNT_OFS);
   assign fast = is_fast(ctrl_r.waveform_mode_field);
   assign clear_on_match_mode = (ctrl_r.waveform_mode_field == TMR_M_CTC_A) ||
      (ctrl_r.waveform_mode_field == TMR_M_CTC_CAP);
   assign mask = fixed_mask(ctrl_r.waveform_mode_field);

   always_comb
   begin
      case (ctrl_r.waveform_mode_field)
         TMR_M_CTC_A, TMR_M_FP_A: top = compare_a_value_r; // RL4 RL10
         TMR_M_CTC_CAP, TMR_M_FP_CAP: top = capture_value_r; // RL4 RL10 RL16
         TMR_M_FP8: top = TMR_TOP8; // RL10
         TMR_M_FP9: top = TMR_TOP9; // RL10
         TMR_M_FP10: top = TMR_TOP10; // RL10
         default: top = TMR_MAX;
      endcase
   end

   assign at_top = (counter_value_r == top) && !block_r;
   assign at_max = (counter_value_r == TMR_MAX);
   assign match_a = (counter_value_r == compare_a_value_r) && !block_r; // RL23
   assign match_b = (counter_value_r == compare_b_value_r) && !block_r; // RL23

   // prescaler: tick every 1, 8, 64, 256 or 1024 clocks; none when stopped
   always_ff @(posedge clock)
   begin
      if (!rstn || ctrl_r.clk_sel == 4'h0 || ctrl_r.clk_sel > 4'h5)
         pre_r <= 11'h000;
      else
         pre_r <= pre_r + 11'h001;
   end

   always_comb
   begin
      case (ctrl_r.clk_sel)
         4'h1: tick = 1'b1;
         4'h2: tick = (pre_r[2:0] == TMR_DIV8[2:0]);
         4'h3: tick = (pre_r[5:0] == TMR_DIV64[5:0]);
         4'h4: tick = (pre_r[7:0] == TMR_DIV256[7:0]);
         4'h5: tick = (pre_r[9:0] == TMR_DIV1024[9:0]);
         default: tick = 1'b0; // RL24
      endcase
   end

   // compare blocking lasts until the next tick after a counter write
   always_ff @(posedge clock)
   begin
      if (!rstn)
         block_r <= 1'b0;
      else if (cnt_wr)
         block_r <= 1'b1; // RL23
      else if (tick)
         block_r <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
         counter_value_r <= TMR_RST16;
      else if (cnt_wr)
         counter_value_r <= wdat; // RL3
      else if (tick)
      begin
         if ((clear_on_match_mode || fast) && at_top)
            counter_value_r <= TMR_ZERO; // RL4 RL11 RL20
         else
            counter_value_r <= counter_value_r + 16'h0001; // RL1 RL5 RL16 RL24
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
         ctrl_r <= TMR_CTRL_RST;
      else if (wr && wb_req.adr == TMR_CTRL_OFS)
         ctrl_r <= wb_req.dat[11:0];
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
         pin_dir_r <= 2'h0;
      else if (wr && wb_req.adr == TMR_PIN_OFS)
         pin_dir_r <= wb_req.dat[1:0];
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
         capture_value_r <= TMR_RST16;
      else if (wr && wb_req.adr == TMR_CAP_OFS)
         capture_value_r <= wdat; // RL16
   end

   // compare a: buffered in fast pwm, direct otherwise
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         compare_a_buf_r <= TMR_RST16;
         compare_b_buf_r <= TMR_RST16;
      end
      else
      begin
         if (wr && wb_req.adr == TMR_CMPA_OFS)
            compare_a_buf_r <= wdat & mask; // RL15 RL17
         if (wr && wb_req.adr == TMR_CMPB_OFS)
            compare_b_buf_r <= wdat & mask; // RL15
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         compare_a_value_r <= TMR_RST16;
         compare_b_value_r <= TMR_RST16;
      end
      else if (!fast)
      begin
         compare_a_value_r <= compare_a_buf_r; // RL5
         compare_b_value_r <= compare_b_buf_r;
      end
      else if (tick && at_top)
      begin
         compare_a_value_r <= compare_a_buf_r; // RL17
         compare_b_value_r <= compare_b_buf_r;
      end
   end

   // flags: hardware set wins over a software write-one clear
   logic [3:0] fset;
   logic [3:0] fclr;
   always_comb
   begin
      fset = 4'h0;
      if (tick)
      begin
         if (fast)
         begin
            fset[TMR_FOVF] = at_top; // RL14
            fset[TMR_FCAP] = at_top && (ctrl_r.waveform_mode_field == TMR_M_FP_CAP); // RL14
            fset[TMR_FCMPA] = match_a; // RL14
         end
         else
         begin
            fset[TMR_FOVF] = at_max; // RL2 RL9
            fset[TMR_FCAP] = clear_on_match_mode && at_top &&
               (ctrl_r.waveform_mode_field == TMR_M_CTC_CAP); // RL6
            fset[TMR_FCMPA] = match_a; // RL6
         end
         fset[TMR_FCMPB] = match_b;
      end
      fclr = (wr && wb_req.adr == TMR_FLAG_OFS) ? wb_req.dat[3:0] : 4'h0;
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
         flags_r <= 4'h0;
      else
         flags_r <= (flags_r & ~fclr) | fset; // RL21 RL2
   end

   // output state per channel
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_wave
         logic [1:0] act;
         logic m;
         assign act = (g == 0) ? ctrl_r.action_a : ctrl_r.action_b;
         assign m = (g == 0) ? match_a : match_b;
         always_ff @(posedge clock)
         begin
            if (!rstn)
               wave_r[g] <= 1'b0;
            else if (tick && act != TMR_OA_NONE) // RL22 RL24
            begin
               if (fast && act != TMR_OA_TOGGLE)
               begin
                  if (m)
                     wave_r[g] <= (act == TMR_OA_SET); // RL12 RL13
                  else if (at_top)
                     wave_r[g] <= (act != TMR_OA_SET); // RL12 RL13
               end
               else if (act == TMR_OA_TOGGLE)
               begin
                  if (m && (g == 0 || !fast))
                     wave_r[g] <= ~wave_r[g]; // RL7
               end
               else if (m)
                  wave_r[g] <= (act == TMR_OA_SET);
            end
         end
      end
   endgenerate

   assign wave_out_a = wave_r[0];
   assign wave_out_b = wave_r[1];
   assign wave_out_a_oe = pin_dir_r[0]; // RL8
   assign wave_out_b_oe = pin_dir_r[1]; // RL8

   // wishbone: one-cycle registered answer
   always_ff @(posedge clock)
   begin
      if (!rstn)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= acc && !wb_ack_o;
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
         wb_dat_o <= 32'h0000_0000;
      else if (acc && !wb_ack_o)
      begin
         case (wb_req.adr)
            TMR_CTRL_OFS: wb_dat_o <= {20'h00000, ctrl_r};
            TMR_FLAG_OFS: wb_dat_o <= {28'h0000000, flags_r};
            TMR_CNT_OFS: wb_dat_o <= {16'h0000, counter_value_r};
            TMR_CMPA_OFS: wb_dat_o <= {16'h0000, compare_a_buf_r};
            TMR_CMPB_OFS: wb_dat_o <= {16'h0000, compare_b_buf_r};
            TMR_CAP_OFS: wb_dat_o <= {16'h0000, capture_value_r};
            TMR_PIN_OFS: wb_dat_o <= {30'h0, pin_dir_r};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // checks
   ovf_normal_a: assert property (@(posedge clock) disable iff (!rstn)
      (tick && !fast && at_max && !cnt_wr) |=>
      flags_r[TMR_FOVF] && counter_value_r == TMR_ZERO)
      else $error("overflow flag missed at wrap"); // RL2
   ctc_clear_a: assert property (@(posedge clock) disable iff (!rstn)
      (tick && clear_on_match_mode && at_top && !cnt_wr) |=> counter_value_r == TMR_ZERO)
      else $error("clear-on-match did not clear"); // RL4
   ctc_ovf_a: assert property (@(posedge clock) disable iff (!rstn)
      (clear_on_match_mode && !at_max && !fclr[TMR_FOVF] && !flags_r[TMR_FOVF]) |=> !flags_r[TMR_FOVF])
      else $error("overflow set outside wrap"); // RL9
   fast_load_a: assert property (@(posedge clock) disable iff (!rstn)
      (tick && fast && at_top) |=> compare_a_value_r == $past(compare_a_buf_r))
      else $error("compare buffer not loaded at top"); // RL17
   fast_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      (fast && $past(fast) && !$past(tick && at_top)) |-> $stable(compare_a_value_r))
      else $error("compare changed mid period"); // RL17
   pin_vis_a: assert property (@(posedge clock) disable iff (!rstn)
      (wr && wb_req.adr == TMR_PIN_OFS) |=> wave_out_a_oe == $past(wb_req.dat[0]))
      else $error("pin enable wrong"); // RL8
   no_tick_a: assert property (@(posedge clock) disable iff (!rstn)
      (!tick && !$past(cnt_wr)) ##1 !$past(cnt_wr) |-> $stable(wave_r))
      else $error("output moved without a tick"); // RL24
   block_a: assert property (@(posedge clock) disable iff (!rstn)
      cnt_wr |=> block_r && !fset[TMR_FCMPA] && !fset[TMR_FCMPB])
      else $error("match not blocked after counter write"); // RL23
   mask_a: assert property (@(posedge clock) disable iff (!rstn)
      (ctrl_r.waveform_mode_field == TMR_M_FP8 && wr && wb_req.adr == TMR_CMPA_OFS)
      |=> compare_a_buf_r[15:8] == 8'h00)
      else $error("fixed top mask missing"); // RL15
   toggle_a: assert property (@(posedge clock) disable iff (!rstn)
      (tick && clear_on_match_mode && match_a && ctrl_r.action_a == TMR_OA_TOGGLE) |=>
      wave_r[0] != $past(wave_r[0]))
      else $error("output a did not toggle"); // RL7
endmodule // tmr_core

// [hw/tmr_pkg.sv]
/*
 16-bit waveform timer package: register map, field layouts, reset values and modes.
 assumes a classic 32-bit wishbone slave with word-aligned registers.
*/
package tmr_pkg;
   localparam logic [7:0] TMR_CTRL_OFS = 8'h00;
   localparam logic [7:0] TMR_FLAG_OFS = 8'h04;
   localparam logic [7:0] TMR_CNT_OFS = 8'h08;
   localparam logic [7:0] TMR_CMPA_OFS = 8'h0c;
   localparam logic [7:0] TMR_CMPB_OFS = 8'h10;
   localparam logic [7:0] TMR_CAP_OFS = 8'h14;
   localparam logic [7:0] TMR_PIN_OFS = 8'h18;
   localparam int TMR_WGM_LSB = 0;
   localparam int TMR_CS_LSB = 4;
   localparam int TMR_COMA_LSB = 8;
   localparam int TMR_COMB_LSB = 10;
   localparam int TMR_FOVF = 0;
   localparam int TMR_FCMPA = 1;
   localparam int TMR_FCMPB = 2;
   localparam int TMR_FCAP = 3;
   localparam logic [15:0] TMR_MAX = 16'hffff;
   localparam logic [15:0] TMR_ZERO = 16'h0000;
   localparam logic [15:0] TMR_TOP8 = 16'h00ff;
   localparam logic [15:0] TMR_TOP9 = 16'h01ff;
   localparam logic [15:0] TMR_TOP10 = 16'h03ff;
   localparam logic [15:0] TMR_RST16 = 16'h0000;
   localparam logic [11:0] TMR_CTRL_RST = 12'h000;
   localparam logic [3:0] TMR_M_NORMAL = 4'h0;
   localparam logic [3:0] TMR_M_CTC_A = 4'h4;
   localparam logic [3:0] TMR_M_FP8 = 4'h5;
   localparam logic [3:0] TMR_M_FP9 = 4'h6;
   localparam logic [3:0] TMR_M_FP10 = 4'h7;
   localparam logic [3:0] TMR_M_CTC_CAP = 4'hc;
   localparam logic [3:0] TMR_M_FP_CAP = 4'he;
   localparam logic [3:0] TMR_M_FP_A = 4'hf;
   localparam logic [1:0] TMR_OA_NONE = 2'h0;
   localparam logic [1:0] TMR_OA_TOGGLE = 2'h1;
   localparam logic [1:0] TMR_OA_CLR = 2'h2;
   localparam logic [1:0] TMR_OA_SET = 2'h3;
   // prescale choices: 0 stopped, then 1, 8, 64, 256, 1024 clocks per tick
   localparam logic [10:0] TMR_DIV8 = 11'h007;
   localparam logic [10:0] TMR_DIV64 = 11'h03f;
   localparam logic [10:0] TMR_DIV256 = 11'h0ff;
   localparam logic [10:0] TMR_DIV1024 = 11'h3ff;
   typedef struct packed {
      logic [1:0] action_b;
      logic [1:0] action_a;
      logic [3:0] clk_sel;
      logic [3:0] waveform_mode_field;
   } tmr_ctrl_s;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } tmr_wb_req_s;
endpackage

// [sim/tmr_tb.sv]
/*
 self-checking bench for the 16-bit waveform timer: counting, clear-on-match, fast pwm, outputs.
 assumes the core acks each wishbone request one cycle after it is taken.
*/
`timescale 1ns/10ps
module tb;
   import tmr_pkg::*;
   logic clock;
   logic rstn;
   tmr_wb_req_s wb_req;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic wave_out_a;
   logic wave_out_a_oe;
   logic wave_out_b;
   logic wave_out_b_oe;
   logic [31:0] exp_q[$];
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [15:0] lfsr = 16'h5820;
   tmr_ctrl_s ctl;
   logic [15:0] cnt;
   logic [16:0] sum;
   int n;
   logic [3:0] cmode [2] = '{TMR_M_CTC_A, TMR_M_CTC_CAP};
   logic [7:0] ctop [2] = '{TMR_CMPA_OFS, TMR_CAP_OFS};
   logic [3:0] fmode [3] = '{TMR_M_FP8, TMR_M_FP9, TMR_M_FP10};
   logic [15:0] ftop [3] = '{TMR_TOP8, TMR_TOP9, TMR_TOP10};

   tmr_core DUT (.clock(clock), .rstn(rstn), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe),
      .wave_out_b(wave_out_b), .wave_out_b_oe(wave_out_b_oe));

   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   function automatic logic [15:0] nxt(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   task automatic give_verdict();
      if (exp_q.size() != 0)
         num_errors++;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge clock);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
      // only the bench timeout ends a wait for ack
      do
         @(posedge clock);
      while (wb_ack_o !== 1'b1);
      wb_req <= '0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      bus(1'b1, adr, dat);
   endtask

   task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
      exp_q.push_back(exp);
      bus(1'b0, adr, 32'h0);
   endtask

   task automatic put_ctl(input logic [3:0] cs);
      ctl.clk_sel = cs;
      wr(TMR_CTRL_OFS, {20'h0, ctl});
   endtask

   // start then stop at divide-by-one: the counter sees n + 3 ticks
   task automatic run(input int k);
      put_ctl(4'h1);
      repeat (k) @(posedge clock);
      put_ctl(4'h0);
      repeat (2) @(posedge clock);
   endtask

   task automatic prep(input logic [3:0] mode, input logic [15:0] c0);
      ctl.waveform_mode_field = mode;
      put_ctl(4'h0);
      wr(TMR_CNT_OFS, {16'h0, c0});
      wr(TMR_FLAG_OFS, 32'hf);
   endtask

   task automatic pwb(input logic [1:0] ab, input logic [15:0] c0, input logic ev);
      ctl.action_b = ab;
      prep(TMR_M_FP8, c0);
      run(0);
      chk({31'h0, wave_out_b}, {31'h0, ev});
   endtask

   // read answers are matched against the oldest expectation
   always @(posedge clock)
   begin
      cycles++;
      if (wb_ack_o === 1'b1 && wb_req.cyc === 1'b1 && wb_req.we === 1'b0)
      begin
         if (exp_q.size() > 0)
            chk(wb_dat_o, exp_q.pop_front());
         else
         begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, wb_dat_o, 32'h0);
         end
      end
      if (cycles > 5000)
      begin
         num_errors++;
         give_verdict();
      end
   end

   initial
   begin
      wb_req = '0;
      rstn = 1'b0;
      ctl = '0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      rd(TMR_CTRL_OFS, 32'h0);
      rd(TMR_FLAG_OFS, 32'h0);
      rd(TMR_CNT_OFS, 32'h0);
      wr(8'h1c, 32'hffffffff);
      rd(8'h1c, 32'h0);
      chk({31'h0, wave_out_a_oe}, 32'h0);
      wr(TMR_CMPA_OFS, 32'h7000);
      wr(TMR_CMPB_OFS, 32'h7000);
      wr(TMR_PIN_OFS, 32'h3);
      $display("reset test done");
      prep(TMR_M_NORMAL, 16'hfffe);
      run(0);
      rd(TMR_CNT_OFS, 32'h1);
      rd(TMR_FLAG_OFS, 32'h1);
      wr(TMR_FLAG_OFS, 32'h1);
      rd(TMR_FLAG_OFS, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         lfsr = nxt(lfsr);
         cnt = {1'b1, lfsr[14:0]};
         n = int'(lfsr[3:0]);
         prep(TMR_M_NORMAL, cnt);
         rd(TMR_CNT_OFS, {16'h0, cnt});
         run(n);
         sum = {1'b0, cnt} + 17'(n + 3);
         rd(TMR_CNT_OFS, {16'h0, sum[15:0]});
         rd(TMR_FLAG_OFS, {31'h0, sum[16]});
      end
      // divide-by-8: about 35 clocks running from a cleared prescaler give four ticks
      prep(TMR_M_NORMAL, 16'h0010);
      put_ctl(4'h2);
      repeat (32) @(posedge clock);
      put_ctl(4'h0);
      rd(TMR_CNT_OFS, 32'h14);
      $display("normal test done");
      ctl.action_a = TMR_OA_TOGGLE;
      for (int i = 0; i < 2; i++)
      begin
         prep(cmode[i], 16'h0000);
         wr(ctop[i], 32'h4 + 32'(i));
         run(5);
         rd(TMR_CNT_OFS, 32'h3 - 32'(i));
         rd(TMR_FLAG_OFS, (i == 0) ? 32'h2 : 32'ha);
         chk({31'h0, wave_out_a}, 32'(1 - i));
         prep(cmode[i], 16'hfffe);
         run(0);
         rd(TMR_CNT_OFS, 32'h1);
         rd(TMR_FLAG_OFS, 32'h1);
      end
      chk({31'h0, wave_out_a_oe}, 32'h1);
      wr(TMR_PIN_OFS, 32'h0);
      repeat (2) @(posedge clock);
      chk({31'h0, wave_out_a_oe}, 32'h0);
      wr(TMR_PIN_OFS, 32'h3);
      $display("clear-on-match test done");
      ctl.action_a = TMR_OA_NONE;
      for (int i = 0; i < 3; i++)
      begin
         prep(fmode[i], ftop[i] - 16'h1);
         wr(TMR_CMPB_OFS, 32'hffff);
         rd(TMR_CMPB_OFS, {16'h0, ftop[i]});
         wr(TMR_CMPB_OFS, 32'h80);
         run(0);
         rd(TMR_CNT_OFS, 32'h1);
         rd(TMR_FLAG_OFS, 32'h1);
      end
      prep(TMR_M_FP_CAP, 16'h000f);
      wr(TMR_CAP_OFS, 32'h10);
      run(0);
      rd(TMR_CNT_OFS, 32'h1);
      rd(TMR_FLAG_OFS, 32'h9);
      prep(TMR_M_FP_A, 16'h0003);
      wr(TMR_CMPA_OFS, 32'h10);
      rd(TMR_CMPA_OFS, 32'h10);
      run(0);
      rd(TMR_CNT_OFS, 32'h1);
      rd(TMR_FLAG_OFS, 32'h3);
      run(0);
      rd(TMR_CNT_OFS, 32'h4);
      pwb(TMR_OA_SET, 16'h007e, 1'b1);
      pwb(TMR_OA_CLR, 16'h007e, 1'b0);
      pwb(TMR_OA_CLR, 16'h00fe, 1'b1);
      pwb(TMR_OA_NONE, 16'h007e, 1'b1);
      pwb(TMR_OA_SET, 16'h00fe, 1'b0);
      chk({31'h0, wave_out_b_oe}, 32'h1);
      $display("fast pwm test done");
      repeat (3) @(posedge clock);
      give_verdict();
   end
endmodule // tb
